// file: hdl/video_afe_top.sv
// Control inputs, sync handling and pixel output of a video front end.
// Assumes ADC samples and reset arrive on the core clock; other pins are async.
// Operation
// - With external clamp selected, a high clamp input connects the clamp.
// - A high phase-invert input moves sampling by half a pixel period.
// - Fast blank comes out delayed to line up with its pixel data.
// - A crystal clock output runs at the crystal rate or half of it.
// - The management port answers at 0x98 or 0x9a per the address strap.
// - The management port is two-wire with open-drain data, host as master.
// - Each pixel leaves as three parallel 10-bit colour words.
// - A pixel data clock and its inverse go out for capture.
// - The aligned hsync output carries pure horizontal sync only.
// - A buffered copy of the active hsync source passes all pulses.
// - For composite sync, vsync out stands while the hsync pattern breaks.
// - An external clock input can replace the internal pixel clock.
// - With external hold selected, the PLL ignores sync edges while held.
// - Data valid is high in active video, low in both blankings.
`timescale 1ns/1ps
`include "afe_defines.svh"
module video_afe_top import afe_pkg::*; #(
   parameter int PIX_W    = `PIX_BITS,
   parameter int PLL_DIV  = `PLL_DIV_DEF,
   parameter int XTAL_DIV = `XTAL_DIV_DEF,
   parameter int H_BACK   = `H_BACK_DEF,
   parameter int H_ACTIVE = `H_ACTIVE_DEF,
   parameter int DEPTH    = `FIFO_DEPTH_DEF
) (
   input  wire logic             core_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             ext_clamp_in_i,
   input  wire logic             ext_clamp_sel_i,
   output logic                  clamp_connect_o,
   input  wire logic             phase_invert_in_i,
   input  wire logic             fast_blank_in_i,
   output logic                  fast_blank_out_o,
   input  wire logic             xclk_half_sel_i,
   output logic                  crystal_clock_out_o,
   input  wire logic             bus_addr_strap_i,
   input  wire logic             scl_i,
   input  wire logic             sda_i,
   output logic                  sda_o,
   output logic                  sda_oe_o,
   input  wire logic             external_clock_in_i,
   input  wire logic             clk_src_ext_i,
   input  wire logic [PIX_W-1:0] red_sample_i,
   input  wire logic [PIX_W-1:0] green_sample_i,
   input  wire logic [PIX_W-1:0] blue_sample_i,
   output logic                  sample_ready_o,
   output logic [PIX_W-1:0]      red_o,
   output logic [PIX_W-1:0]      green_o,
   output logic [PIX_W-1:0]      blue_o,
   output logic                  data_clk_o,
   output logic                  data_clk_n_o,
   input  wire logic             pixel_ready_i,
   input  wire logic             hsync_in_i,
   input  wire logic             vsync_in_i,
   input  wire logic             sync_on_green_i,
   input  wire logic [1:0]       sync_src_i,
   input  wire logic             pll_hold_in_i,
   input  wire logic             pll_hold_sel_i,
   output logic                  aligned_hsync_out_o,
   output logic                  buffered_hsync_out_o,
   output logic                  buffered_vsync_out_o,
   output logic                  video_valid_out_o
);
   localparam int WORD_W = 3 * PIX_W + 3;
   localparam logic [11:0] WIDE_CYC = 12'(`HS_WIDE_CYC);
   localparam logic [11:0] DE_FROM  = 12'(H_BACK);
   localparam logic [11:0] DE_TO    = 12'(H_BACK + H_ACTIVE);
   localparam logic [7:0]  PLL_LAST = 8'(PLL_DIV - 1);
   localparam logic [7:0]  PLL_HALF = 8'(PLL_DIV / 2);
   localparam logic [7:0]  XT_LAST  = 8'(XTAL_DIV - 1);

   // Counters are 8 and 12 bits wide; refuse what they cannot hold
   if (PLL_DIV < 2 || PLL_DIV > 255 || XTAL_DIV < 1 || XTAL_DIV > 128 ||
       H_BACK + H_ACTIVE > 4095 || H_ACTIVE < 1) begin : g_chk
      $error("video_afe_top parameter out of range");
   end

   // Edge helpers on synchronised levels
   function automatic logic rose(input logic now, input logic was);
      return now & ~was;
   endfunction
   function automatic logic fell(input logic now, input logic was);
      return ~now & was;
   endfunction

   // Pin synchroniser: the first stage feeds only the second
   logic [`SYNC_PINS-1:0] meta_ff, pin_ff;
   always_ff @(posedge core_clk_i) begin
      meta_ff <= {ext_clamp_in_i, ext_clamp_sel_i, phase_invert_in_i,
                  fast_blank_in_i, xclk_half_sel_i, external_clock_in_i,
                  clk_src_ext_i, hsync_in_i, vsync_in_i, sync_on_green_i,
                  pll_hold_in_i, pll_hold_sel_i, pixel_ready_i};
      pin_ff  <= meta_ff;
   end

   logic clamp_s, clamp_sel_s, inv_s, fb_s, half_s, xclk_s, ext_sel_s;
   logic hs_s, vs_s, sog_s, hold_s, hold_sel_s, down_rdy_s;
   assign {clamp_s, clamp_sel_s, inv_s, fb_s, half_s, xclk_s, ext_sel_s,
           hs_s, vs_s, sog_s, hold_s, hold_sel_s, down_rdy_s} = pin_ff;

   // Sync source select is a static strap-like setting, sampled too
   logic [1:0] src_meta_ff, src_ff;
   always_ff @(posedge core_clk_i) begin
      src_meta_ff <= sync_src_i;
      src_ff      <= src_meta_ff;
   end

   // Sync, PLL and line timing state
   logic        src_hs, composite, hs_pure, src_clk, pix_stb, de;
   logic        hs_q_ff, vs_det_ff, nxt_vs_det, pure_q_ff, clk_q_ff;
   logic        bufhs_ff, bufvs_ff, clamp_ff, nxt_bufvs;
   logic [11:0] wid_ff, nxt_wid, pix_ff, nxt_pix;
   logic [7:0]  pll_ff, nxt_pll;

   always_comb begin
      src_hs    = (sync_src_e'(src_ff) == SRC_SOG) ? sog_s : hs_s;
      composite = sync_src_e'(src_ff) != SRC_SEPARATE;
      // Broad pulses in the vertical interval must not reach hsync
      hs_pure   = src_hs & ~(composite & vs_det_ff);
      // Pulse width counter, saturating
      nxt_wid = src_hs ? ((wid_ff == '1) ? wid_ff : wid_ff + 12'h1) : '0;
      // Broad pulse marks the break; first normal pulse ends it
      nxt_vs_det = vs_det_ff;
      if (src_hs && wid_ff >= WIDE_CYC) begin
         nxt_vs_det = 1'b1;
      end else if (fell(src_hs, hs_q_ff) && wid_ff < WIDE_CYC) begin
         nxt_vs_det = 1'b0;
      end
      nxt_bufvs = composite ? vs_det_ff : vs_s;
      // PLL model: divider re-phased on each hsync unless held
      // Hold freezes the phase only; the divider keeps counting
      nxt_pll = (pll_ff == PLL_LAST) ? '0 : pll_ff + 8'h1;
      if (rose(src_hs, hs_q_ff) && !(hold_sel_s && hold_s)) begin
         nxt_pll = '0;
      end
      src_clk = ext_sel_s ? xclk_s : (pll_ff < PLL_HALF);
      // Falling edge instead of rising is half a pixel later
      pix_stb = inv_s ? fell(src_clk, clk_q_ff)
                      : rose(src_clk, clk_q_ff);
      // Pixels counted from the start of each pure hsync pulse
      nxt_pix = pix_ff;
      if (rose(hs_pure, pure_q_ff)) begin
         nxt_pix = '0;
      end else if (pix_stb && pix_ff != '1) begin
         nxt_pix = pix_ff + 12'h1;
      end
      de = ~bufvs_ff & (pix_ff >= DE_FROM) & (pix_ff < DE_TO);
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         hs_q_ff   <= 1'b0;
         pure_q_ff <= 1'b0;
         clk_q_ff  <= 1'b0;
         vs_det_ff <= 1'b0;
         bufhs_ff  <= 1'b0;
         bufvs_ff  <= 1'b0;
         clamp_ff  <= 1'b0;
         wid_ff    <= '0;
         pix_ff    <= '1;
         pll_ff    <= '0;
      end else begin
         hs_q_ff   <= src_hs;
         pure_q_ff <= hs_pure;
         clk_q_ff  <= src_clk;
         vs_det_ff <= nxt_vs_det;
         bufhs_ff  <= src_hs;
         bufvs_ff  <= nxt_bufvs;
         clamp_ff  <= clamp_sel_s & clamp_s;
         wid_ff    <= nxt_wid;
         pix_ff    <= nxt_pix;
         pll_ff    <= nxt_pll;
      end
   end

   // Crystal clock divider: half rate doubles the toggle interval
   logic [7:0] xt_ff, nxt_xt;
   logic       xt_half_ff, nxt_xt_half, xclk_ff, nxt_xclk;
   always_comb begin
      nxt_xt      = xt_ff;
      nxt_xt_half = xt_half_ff;
      nxt_xclk    = xclk_ff;
      if (xt_ff == XT_LAST) begin
         nxt_xt      = '0;
         nxt_xt_half = ~xt_half_ff;
         if (!half_s || xt_half_ff) begin
            nxt_xclk = ~xclk_ff;
         end
      end else begin
         nxt_xt = xt_ff + 8'h1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         xt_ff      <= '0;
         xt_half_ff <= 1'b0;
         xclk_ff    <= 1'b0;
      end else begin
         xt_ff      <= nxt_xt;
         xt_half_ff <= nxt_xt_half;
         xclk_ff    <= nxt_xclk;
      end
   end

   // One word carries every per-pixel field through the same path
   logic [WORD_W-1:0] in_word, out_word;
   logic              in_rdy, out_vld, pop;
   assign in_word = {fb_s, hs_pure, de, red_sample_i, green_sample_i,
                     blue_sample_i};

   // Samples offered while full are dropped; sample_ready_o warns the ADC
   pix_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .core_clk_i  (core_clk_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (pix_stb),
      .in_ready_o  (in_rdy),
      .in_data_i   (in_word),
      .out_valid_o (out_vld),
      .out_ready_i (pop),
      .out_data_o  (out_word)
   );

   // Output stage: new word on the falling data clock, rise one cycle on
   logic             dclk_ff, nxt_dclk, rdy_ff, fbo_ff, hso_ff, deo_ff;
   logic             dclk_n_ff;
   logic [PIX_W-1:0] r_ff, g_ff, b_ff;
   always_comb begin
      pop      = out_vld & down_rdy_s & dclk_ff;
      nxt_dclk = pop ? 1'b0 : 1'b1;
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         dclk_ff <= 1'b1;
         dclk_n_ff <= 1'b0;
         rdy_ff  <= 1'b0;
         fbo_ff  <= 1'b0;
         hso_ff  <= 1'b0;
         deo_ff  <= 1'b0;
         r_ff    <= '0;
         g_ff    <= '0;
         b_ff    <= '0;
      end else begin
         dclk_ff <= nxt_dclk;
         // Own flop, so the pair never skews by a gate
         dclk_n_ff <= ~nxt_dclk;
         rdy_ff  <= in_rdy;
         if (pop) begin
            {fbo_ff, hso_ff, deo_ff, r_ff, g_ff, b_ff} <= out_word;
         end
      end
   end

   two_wire_slave u_mgmt (
      .core_clk_i   (core_clk_i),
      .reset_n_i    (reset_n_i),
      .scl_i        (scl_i),
      .sda_i        (sda_i),
      .addr_strap_i (bus_addr_strap_i),
      .sda_o        (sda_o),
      .sda_oe_o     (sda_oe_o)
   );

   // All outputs straight from flops
   assign clamp_connect_o      = clamp_ff;
   assign fast_blank_out_o     = fbo_ff;
   assign crystal_clock_out_o  = xclk_ff;
   assign sample_ready_o       = rdy_ff;
   assign red_o                = r_ff;
   assign green_o              = g_ff;
   assign blue_o               = b_ff;
   assign data_clk_o           = dclk_ff;
   assign data_clk_n_o         = dclk_n_ff;
   assign aligned_hsync_out_o  = hso_ff;
   assign buffered_hsync_out_o = bufhs_ff;
   assign buffered_vsync_out_o = bufvs_ff;
   assign video_valid_out_o    = deo_ff;
endmodule

// file: hdl/afe_defines.svh
// Constants for the video front end control and pixel output block.
// Assumes a single 10 MHz core clock; included by bare name.
`ifndef AFE_DEFINES_SVH
`define AFE_DEFINES_SVH

`define CORE_CLK_NS    100
`define RESET_MIN_NS   1000
`define RESET_MIN_CYC  ((`RESET_MIN_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define PIX_BITS       10
`define PLL_DIV_DEF    8
`define XTAL_DIV_DEF   1
`define HS_WIDE_NS     4000
`define HS_WIDE_CYC    (`HS_WIDE_NS / `CORE_CLK_NS)
`define H_BACK_DEF     4
`define H_ACTIVE_DEF   16
`define FIFO_DEPTH_DEF 8
`define TW_ADDR_LOW    7'h4c
`define TW_ADDR_HIGH   7'h4d
`define TW_BITS        4'h8
`define SYNC_PINS      13

`endif

// file: hdl/afe_pkg.sv
// Types shared by the front end control and pixel output modules.
// Assumes afe_defines.svh supplies every numeric constant.
package afe_pkg;

   // Active horizontal sync source
   typedef enum logic [1:0] {
      SRC_SEPARATE  = 2'h0,
      SRC_COMPOSITE = 2'h1,
      SRC_SOG       = 2'h3
   } sync_src_e;

   // Two-wire slave states, Gray along the write path
   typedef enum logic [2:0] {
      TW_IDLE = 3'h0,
      TW_ADDR = 3'h1,
      TW_AACK = 3'h3,
      TW_DATA = 3'h2,
      TW_DACK = 3'h6,
      TW_SKIP = 3'h7
   } tw_state_e;

endpackage

// file: hdl/pix_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "afe_defines.svh"
module pix_fifo import afe_pkg::*; #(
   parameter int WIDTH = 33,
   parameter int DEPTH = `FIFO_DEPTH_DEF
) (
   input  wire logic             core_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   // Pointers need a power of two so that wrap is free
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("pix_fifo DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0]      wr_ff, rd_ff, nxt_wr, nxt_rd;
   logic             push, pop;

   // Extra pointer bit tells full from empty
   always_comb begin
      in_ready_o  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
      out_valid_o = wr_ff != rd_ff;
      out_data_o  = mem_ff[rd_ff[AW-1:0]];
      push        = in_valid_i & in_ready_o;
      pop         = out_valid_o & out_ready_i;
      nxt_wr      = push ? wr_ff + 1'b1 : wr_ff;
      nxt_rd      = pop ? rd_ff + 1'b1 : rd_ff;
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
   end

   // Storage is not reset; only written words are ever read
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_ff[wr_ff[AW-1:0]] <= in_data_i;
      end
   end
endmodule

// file: hdl/two_wire_slave.sv
// Two-wire management port: address match and acknowledge only.
// Assumes raw pins at the ports; they are synchronised here.
`timescale 1ns/1ps
`include "afe_defines.svh"
module two_wire_slave import afe_pkg::*; (
   input  wire logic core_clk_i,
   input  wire logic reset_n_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic addr_strap_i,
   output logic      sda_o,
   output logic      sda_oe_o
);
   logic [2:0] meta_ff, sync_ff;
   logic       scl_q_ff, sda_q_ff, strap_ff, strap_done_ff;
   tw_state_e  state_ff, nxt_state;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [7:0] sh_ff, nxt_sh;
   logic       oe_ff, nxt_oe, rd_ff, nxt_rd;
   logic       scl, sda, rise, fall, start, stop;
   logic [6:0] my_addr;

   // Pins pass two flops; strap is caught once after reset release
   always_ff @(posedge core_clk_i) begin
      meta_ff  <= {addr_strap_i, sda_i, scl_i};
      sync_ff  <= meta_ff;
      scl_q_ff <= sync_ff[0];
      sda_q_ff <= sync_ff[1];
      if (!reset_n_i) begin
         strap_done_ff <= 1'b0;
         strap_ff      <= 1'b0;
      end else if (!strap_done_ff) begin
         strap_done_ff <= 1'b1;
         strap_ff      <= sync_ff[2];
      end
   end

   // Bus events; a start inside a byte restarts the address phase
   always_comb begin
      scl     = sync_ff[0];
      sda     = sync_ff[1];
      rise    = scl & ~scl_q_ff;
      fall    = ~scl & scl_q_ff;
      start   = scl & scl_q_ff & sda_q_ff & ~sda;
      stop    = scl & scl_q_ff & ~sda_q_ff & sda;
      my_addr = strap_ff ? `TW_ADDR_HIGH : `TW_ADDR_LOW;
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_sh    = sh_ff;
      nxt_oe    = oe_ff;
      nxt_rd    = rd_ff;
      if (start) begin
         nxt_state = TW_ADDR;
         nxt_cnt   = '0;
         nxt_oe    = 1'b0;
      end else if (stop) begin
         nxt_state = TW_IDLE;
         nxt_oe    = 1'b0;
      end else begin
         case (state_ff)
            TW_ADDR, TW_DATA: begin
               if (rise) begin
                  nxt_sh  = {sh_ff[6:0], sda};
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (fall && cnt_ff == `TW_BITS) begin
                  if (state_ff == TW_DATA) begin
                     nxt_state = TW_DACK;
                     nxt_oe    = 1'b1;
                  end else if (sh_ff[7:1] == my_addr) begin
                     nxt_state = TW_AACK;
                     nxt_oe    = 1'b1;
                     nxt_rd    = sh_ff[0];
                  end else begin
                     nxt_state = TW_SKIP;
                  end
               end
            end
            TW_AACK, TW_DACK: begin
               if (fall) begin
                  nxt_oe    = 1'b0;
                  nxt_cnt   = '0;
                  // Reads return released bus, so the master sees ones
                  nxt_state = rd_ff ? TW_SKIP : TW_DATA;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         state_ff <= TW_IDLE;
         cnt_ff   <= '0;
         sh_ff    <= '0;
         oe_ff    <= 1'b0;
         rd_ff    <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         sh_ff    <= nxt_sh;
         oe_ff    <= nxt_oe;
         rd_ff    <= nxt_rd;
      end
   end

   // Open drain: only ever pulls low
   assign sda_o    = 1'b0;
   assign sda_oe_o = oe_ff;
endmodule

// file: tb/afe_monitor.sv
// Port-level assertions for the video front end top module.
// Bound onto video_afe_top; one core clock, synchronous reset.
`timescale 1ns/1ps
module afe_monitor #(
   parameter int PIX_W    = 10,
   parameter int XTAL_DIV = 1
) (
   input wire logic             core_clk_i,
   input wire logic             reset_n_i,
   input wire logic             ext_clamp_in_i,
   input wire logic             ext_clamp_sel_i,
   input wire logic             clamp_connect_o,
   input wire logic             fast_blank_out_o,
   input wire logic             xclk_half_sel_i,
   input wire logic             crystal_clock_out_o,
   input wire logic             sda_o,
   input wire logic [PIX_W-1:0] red_o,
   input wire logic [PIX_W-1:0] green_o,
   input wire logic [PIX_W-1:0] blue_o,
   input wire logic             data_clk_o,
   input wire logic             data_clk_n_o,
   input wire logic             hsync_in_i,
   input wire logic [1:0]       sync_src_i,
   input wire logic             aligned_hsync_out_o,
   input wire logic             buffered_hsync_out_o,
   input wire logic             buffered_vsync_out_o,
   input wire logic             video_valid_out_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   // Pins pass two synchronising flops, so inputs must settle first
   chk_clamp_on : assert property (
      (ext_clamp_sel_i && ext_clamp_in_i)[*5] |-> clamp_connect_o)
      else $error("clamp not connected");
   chk_fblank_align : assert property (
      $changed(fast_blank_out_o) |-> $fell(data_clk_o))
      else $error("fast blank moved off a pixel");
   chk_pixel_align : assert property (
      $changed({red_o, green_o, blue_o, aligned_hsync_out_o,
                video_valid_out_o}) |-> $fell(data_clk_o))
      else $error("pixel fields moved apart");
   chk_clk_inverse : assert property (
      data_clk_n_o == !data_clk_o) else $error("clock pair not inverse");
   chk_clk_low_one : assert property (
      $fell(data_clk_o) |=> data_clk_o) else $error("data clock low twice");
   // Only the default divider is checked here; others need a counter
   chk_xclk_full : assert property (
      (XTAL_DIV == 1 && !xclk_half_sel_i)[*6] |->
         crystal_clock_out_o != $past(crystal_clock_out_o))
      else $error("crystal clock not at full rate");
   chk_sda_open : assert property (
      sda_o == 1'b0) else $error("data line driven high");
   chk_bufhs_copy : assert property (
      (sync_src_i != 2'h3)[*4] |->
         buffered_hsync_out_o == $past(hsync_in_i, 3))
      else $error("buffered hsync differs from source");

   cover property ($fell(data_clk_o));
   cover property ($rose(buffered_vsync_out_o));
   cover property ($rose(clamp_connect_o));
endmodule

bind video_afe_top afe_monitor #(.PIX_W(PIX_W), .XTAL_DIV(XTAL_DIV))
   afe_monitor_i (
   .core_clk_i, .reset_n_i, .ext_clamp_in_i, .ext_clamp_sel_i,
   .clamp_connect_o, .fast_blank_out_o, .xclk_half_sel_i,
   .crystal_clock_out_o, .sda_o, .red_o, .green_o, .blue_o, .data_clk_o,
   .data_clk_n_o, .hsync_in_i, .sync_src_i, .aligned_hsync_out_o,
   .buffered_hsync_out_o, .buffered_vsync_out_o, .video_valid_out_o);

// file: tb/pixel_sink_model.sv
// Downstream pixel receiver: takes a word at each data clock rise.
// Runs on the core clock; stalls the block through its ready pin.
`timescale 1ns/1ps
module pixel_sink_model (
   input  wire logic       core_clk_i,
   input  wire logic       stall_i,
   input  wire logic       data_clk_i,
   input  wire logic [9:0] red_i,
   input  wire logic [9:0] green_i,
   input  wire logic [9:0] blue_i,
   input  wire logic       fast_blank_i,
   output logic            pixel_ready_o
);
   logic        clk_seen;
   logic [30:0] got_q[$];

   // Ready drops while stalled; words are only trusted at the rise
   always @(posedge core_clk_i) begin
      pixel_ready_o <= !stall_i;
      clk_seen <= data_clk_i;
      if (data_clk_i && !clk_seen) begin
         got_q.push_back({fast_blank_i, red_i, green_i, blue_i});
      end
   end
endmodule

// file: tb/video_afe_control_and_pixel_output_tb_top.sv
// Self-checking bench for the video front end control and pixel output.
// Drives every pin on the core clock; a sink model takes the pixels.
`timescale 1ns/1ps
module video_afe_control_and_pixel_output_tb_top;
   logic       core_clk_i, reset_n_i, ext_clamp_in_i, ext_clamp_sel_i;
   logic       phase_invert_in_i, fast_blank_in_i, xclk_half_sel_i;
   logic       bus_addr_strap_i, scl_i, external_clock_in_i, clk_src_ext_i;
   logic       pixel_ready_i, hsync_in_i, vsync_in_i, sync_on_green_i;
   logic       pll_hold_in_i, pll_hold_sel_i, stall, sda_drv, saw_full;
   logic [1:0] sync_src_i;
   logic [9:0] red_sample_i, green_sample_i, blue_sample_i;
   logic       clamp_connect_o, fast_blank_out_o, crystal_clock_out_o;
   logic       sda_o, sda_oe_o, sample_ready_o, data_clk_o, data_clk_n_o;
   logic       aligned_hsync_out_o, buffered_hsync_out_o;
   logic       buffered_vsync_out_o, video_valid_out_o;
   logic [9:0] red_o, green_o, blue_o;
   wire        sda_i = sda_drv & !sda_oe_o; // Pulled-up open drain
   int         fails, checks, seq_k, n;
   logic       p;

   video_afe_top video_afe_top_i (.*);
   pixel_sink_model pixel_sink_model_i (
      .core_clk_i, .stall_i(stall), .data_clk_i(data_clk_o),
      .red_i(red_o), .green_i(green_o), .blue_i(blue_o),
      .fast_blank_i(fast_blank_out_o), .pixel_ready_o(pixel_ready_i));

   always #50 core_clk_i = !core_clk_i;

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk_i);
   endtask

   task automatic do_reset(input logic strap);
      cyc(1);
      reset_n_i <= 1'b0;
      bus_addr_strap_i <= strap;
      cyc(12); // Over one microsecond low
      reset_n_i <= 1'b1;
      cyc(4);
      #1;
      chk("clock pair idle", {data_clk_o, data_clk_n_o}, 2'h2);
   endtask

   // A bad word sits on the inputs around the edge that must not sample
   task automatic put_sample(input logic good);
      if (good) begin
         seq_k++;
         red_sample_i <= seq_k[9:0];
         green_sample_i <= ~seq_k[9:0];
         blue_sample_i <= seq_k[9:0] + 10'h1;
      end else begin
         green_sample_i <= seq_k[9:0];
      end
   endtask

   task automatic run_pixels(input logic inv, input int cnt, input int st);
      logic [30:0] w;
      int          gaps;
      gaps = 0;
      pixel_sink_model_i.got_q.delete();
      cyc(1);
      vsync_in_i <= 1'b1;
      cyc(2);
      phase_invert_in_i <= inv; // Moved only inside vertical sync
      cyc(2);
      vsync_in_i <= 1'b0;
      for (int i = 0; i < cnt; i++) begin
         stall <= i >= st && i < st + 16;
         external_clock_in_i <= 1'b1;
         if (!inv) fast_blank_in_i <= !seq_k[0]; // Same sync path as clock
         cyc(2);
         put_sample(!inv);
         cyc(2);
         external_clock_in_i <= 1'b0;
         if (inv) fast_blank_in_i <= !seq_k[0];
         cyc(2);
         put_sample(inv);
         cyc(2);
         if (sample_ready_o === 1'b0) saw_full = 1'b1;
      end
      cyc(60);
      foreach (pixel_sink_model_i.got_q[j]) begin
         w = pixel_sink_model_i.got_q[j];
         chk("green word", w[19:10], 10'(~w[29:20]));
         chk("blue word", w[9:0], 10'(w[29:20] + 10'h1));
         chk("fast blank", w[30], w[20]);
         if (j > 0 && w[29:20] !==
             pixel_sink_model_i.got_q[j-1][29:20] + 10'h1) gaps++;
      end
      chk("stream gaps", gaps, st < cnt);
      if (st >= cnt) chk("words", pixel_sink_model_i.got_q.size(), cnt);
   endtask

   task automatic hpulse(input int wid);
      cyc(1);
      hsync_in_i <= 1'b1;
      cyc(wid);
      hsync_in_i <= 1'b0;
      cyc(30);
   endtask

   // SCL phases of six cycles leave room for the pin synchronisers
   task automatic tw_addr(input logic [7:0] a, input logic ack);
      logic seen;
      cyc(1);
      sda_drv <= 1'b0;
      cyc(6);
      scl_i <= 1'b0;
      for (int b = 8; b >= 0; b--) begin
         sda_drv <= b > 0 ? a[b-1] : 1'b1;
         cyc(6);
         scl_i <= 1'b1;
         cyc(6);
         seen = sda_i;
         scl_i <= 1'b0;
      end
      cyc(6);
      sda_drv <= 1'b0;
      cyc(6);
      scl_i <= 1'b1;
      cyc(6);
      sda_drv <= 1'b1;
      cyc(6);
      #1;
      chk("address ack", !seen, ack);
      chk("line released", sda_oe_o, 1'b0);
   endtask

   initial begin
      {core_clk_i, reset_n_i, ext_clamp_in_i, ext_clamp_sel_i} = '0;
      {phase_invert_in_i, fast_blank_in_i, xclk_half_sel_i, stall} = '0;
      {bus_addr_strap_i, external_clock_in_i, hsync_in_i, vsync_in_i} = '0;
      {sync_on_green_i, pll_hold_in_i, pll_hold_sel_i, saw_full} = '0;
      {scl_i, sda_drv, clk_src_ext_i} = 3'h7;
      sync_src_i = 2'h0;
      {red_sample_i, green_sample_i, blue_sample_i} = 30'h000ffc01;
      fails = 0;
      checks = 0;
      seq_k = 0;
      do_reset(1'b0);
      for (int i = 0; i < 4; i++) begin
         cyc(1);
         {ext_clamp_sel_i, ext_clamp_in_i} <= i[1:0];
         cyc(6);
         #1;
         chk("clamp", clamp_connect_o, i == 3);
      end
      for (int h = 0; h < 2; h++) begin
         cyc(1);
         xclk_half_sel_i <= h[0];
         cyc(8);
         #1;
         p = crystal_clock_out_o;
         n = 0;
         repeat (40) begin
            @(posedge core_clk_i);
            #1;
            n += (crystal_clock_out_o !== p);
            p = crystal_clock_out_o;
         end
         chk("crystal toggles", n, h ? 20 : 40);
      end
      run_pixels(1'b0, 24, 99);
      run_pixels(1'b1, 24, 99);
      run_pixels(1'b0, 40, 6);
      chk("fifo refused", saw_full, 1'b1);
      cyc(1);
      sync_src_i <= 2'h1;
      hpulse(10);
      hpulse(10);
      hsync_in_i <= 1'b1;
      cyc(48);
      #1;
      chk("vsync in broad pulse", buffered_vsync_out_o, 1'b1);
      chk("composite passed", buffered_hsync_out_o, 1'b1);
      cyc(1);
      hsync_in_i <= 1'b0;
      cyc(20);
      #1;
      chk("vsync to next line", buffered_vsync_out_o, 1'b1);
      hpulse(10);
      #1;
      chk("vsync ended", buffered_vsync_out_o, 1'b0);
      cyc(1);
      sync_src_i <= 2'h0;
      hpulse(10);
      for (int s = 0; s < 2; s++) begin
         do_reset(s[0]);
         tw_addr(8'h98, s == 0);
         tw_addr(8'h99, s == 0);
         tw_addr(8'h9a, s == 1);
         tw_addr(8'h9b, s == 1);
      end
      give_verdict();
   end

   // The sequence needs about 2400 cycles; this cuts a hang short
   initial begin
      cyc(20000);
      fails++;
      give_verdict();
   end
endmodule
